// ==== bench/bt_far_model.sv ====
// far side model: card logic on port a, terminated backplane on port b
`timescale 1ns/1ps
module bt_far_model (
  input wire logic [bt_pkg::DATA_W-1:0] card_a,
  input wire logic card_en,
  input wire logic [bt_pkg::DATA_W-1:0] bp_b,
  input wire logic bp_en,
  input wire logic [bt_pkg::DATA_W-1:0] a_out,
  input wire logic a_oe,
  input wire logic [bt_pkg::DATA_W-1:0] b_out,
  input wire logic b_oe,
  output logic [bt_pkg::DATA_W-1:0] a_wire,
  output logic [bt_pkg::DATA_W-1:0] b_wire
);
  logic [bt_pkg::DATA_W-1:0] last_reg; // last level actively driven on port a
  // port a: device, else card, else floating lines show the opposite level
  always_comb begin
    a_wire = a_oe ? a_out : (card_en ? card_a : ~last_reg);
  end
  // remember the last driven level so a stray sample of a released port shows up
  always @(a_oe, a_out, card_en, card_a) begin
    if (a_oe) begin
      last_reg = a_out;
    end else if (card_en) begin
      last_reg = card_a;
    end
  end
  // port b: released lines are pulled high by termination
  assign b_wire = b_oe ? b_out : (bp_en ? bp_b : '1);
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench of the latched bus transceiver
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam int W = bt_pkg::DATA_W;
  logic clk = 0, rst = 1, card_en = 1, bp_en = 0;
  logic [W-1:0] card_a = '0, bp_b = '0, a_out, b_out, a_wire, b_wire;
  logic a_oe, b_oe, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic ab_oe_n = 1, ab_le = 0, ab_clk = 0, ab_ce_n = 1; // outputs off at power
  logic ba_oe_n = 1, ba_le = 0, ba_clk = 0, ba_ce_n = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic er;
  int failures = 0, n_checks = 0;
  always #25 clk = ~clk;
  bt_transceiver bt_transceiver_i (.SYS_CLK(clk), .RST(rst), .A_IN(a_wire), .A_OUT(a_out),
    .A_OE(a_oe), .B_IN(b_wire), .B_OUT(b_out), .B_OE(b_oe), .AB_OUTPUT_ENABLE_N(ab_oe_n),
    .AB_LATCH_ENABLE(ab_le), .AB_CLOCK(ab_clk), .AB_CLOCK_ENABLE_N(ab_ce_n),
    .BA_OUTPUT_ENABLE_N(ba_oe_n), .BA_LATCH_ENABLE(ba_le), .BA_CLOCK(ba_clk),
    .BA_CLOCK_ENABLE_N(ba_ce_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  bt_far_model bt_far_model_i (.card_a(card_a), .card_en(card_en), .bp_b(bp_b),
    .bp_en(bp_en), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .a_wire(a_wire), .b_wire(b_wire));
  // controls as {oe_n, le, clk, ce_n}, then wait past sync latency
  task ab_set(input logic [3:0] v);
    @(posedge clk) {ab_oe_n, ab_le, ab_clk, ab_ce_n} <= v;
    repeat (5) @(posedge clk);
  endtask
  task ba_set(input logic [3:0] v);
    @(posedge clk) {ba_oe_n, ba_le, ba_clk, ba_ce_n} <= v;
    repeat (5) @(posedge clk);
  endtask
  task card(input logic [W-1:0] v);
    @(posedge clk) card_a <= v;
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    `CHK("pready", 1, k < 20)
  endtask
  task t_reset;
    `CHK("b_oe", 1'b0, b_oe)
    `CHK("a_oe", 1'b0, a_oe)
  endtask
  // latch open: output follows whatever clock does
  task t_transp;
    card(18'h2a5a5);
    ab_set(4'h4);
    `CHK("b", 18'h2a5a5, b_wire)
    `CHK("b_oe", 1'b1, b_oe)
    card(18'h15a5a);
    ab_set(4'h7);
    `CHK("b", 18'h15a5a, b_wire)
  endtask
  // clock high when latch closes, then steady clock levels
  task t_latch;
    ab_set(4'h2);
    card(18'h00fff);
    ab_set(4'h2);
    `CHK("b", 18'h15a5a, b_wire)
    ab_set(4'h0);
    `CHK("b", 18'h15a5a, b_wire)
  endtask
  // enabled rising edges load, falling edges and rising edges with clock enable high do not
  task t_clock;
    card(18'h3ffff);
    ab_set(4'h2);
    `CHK("b", 18'h3ffff, b_wire)
    card(18'h00000);
    ab_set(4'h0);
    `CHK("b", 18'h3ffff, b_wire)
    ab_set(4'h2);
    `CHK("b", 18'h00000, b_wire)
    ab_set(4'h1);
    card(18'h12345);
    ab_set(4'h3);
    `CHK("b", 18'h00000, b_wire)
  endtask
  // isolation beats latch, store still loads behind it
  task t_isolate;
    ab_set(4'he);
    `CHK("b_oe", 1'b0, b_oe)
    `CHK("b", 18'h3ffff, b_wire)
    card(18'h0abcd);
    ab_set(4'h8);
    ab_set(4'ha);
    ab_set(4'h2);
    `CHK("b", 18'h0abcd, b_wire)
  endtask
  // mirror direction from backplane to card
  task t_ba;
    ab_set(4'h9);
    @(posedge clk) {card_en, bp_en, bp_b} <= {2'b01, 18'h2468a};
    ba_set(4'h4);
    `CHK("a", 18'h2468a, a_wire)
    `CHK("a_oe", 1'b1, a_oe)
    ba_set(4'h0);
    @(posedge clk) bp_b <= 18'h13579;
    ba_set(4'h2);
    `CHK("a", 18'h13579, a_wire)
    @(posedge clk) bp_b <= '0;
    ba_set(4'h1);
    ba_set(4'h3);
    `CHK("a", 18'h13579, a_wire)
    ba_set(4'h9);
  endtask
  // status codes, view select, read-only and unmapped places
  task t_apb;
    @(posedge clk) {card_en, bp_en} <= 2'b10;
    card(18'h0f0f0);
    ab_set(4'h4);
    apb(1'b0, 12'h004, '0);
    `CHK("status", 32'h00000011, rd)
    `CHK("slverr", 1'b0, er)
    ab_set(4'h0);
    apb(1'b0, 12'h004, '0);
    `CHK("status", 32'h00000012, rd)
    ab_set(4'h1);
    apb(1'b1, 12'h004, 32'hffffffff);
    apb(1'b0, 12'h004, '0);
    `CHK("status", 32'h00000013, rd)
    apb(1'b0, 12'h008, '0);
    `CHK("view", 32'h0000f0f0, rd)
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h000, '0);
    `CHK("ctrl", 32'h00000001, rd)
    apb(1'b0, 12'h008, '0);
    `CHK("view", 32'h00013579, rd)
    apb(1'b0, 12'h00c, '0);
    `CHK("slverr", 1'b1, er)
    `CHK("rdata", 32'h0, rd)
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_transp();
    t_latch();
    t_clock();
    t_isolate();
    t_ba();
    t_apb();
    print_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule

// ==== verilog/bt_path.sv ====
// one direction of the transceiver: store, drive enable and mode
`timescale 1ns/1ps
module bt_path (
  input wire logic clk,
  input wire logic rst,
  input wire logic [bt_pkg::DATA_W-1:0] din,
  input wire logic oe_n,
  input wire logic le,
  input wire logic pclk,
  input wire logic ce_n,
  output logic [bt_pkg::DATA_W-1:0] dout,
  output logic drive_en,
  output bt_pkg::bt_mode_t mode
);
  logic [bt_pkg::DATA_W-1:0] store_reg, store_next; // per-bit storage element
  logic drive_reg, drive_next; // output driver on
  logic clk_d_reg, clk_d_next; // previous path clock level
  bt_pkg::bt_mode_t mode_reg, mode_next; // decoded mode
  logic edge_up; // rising path clock

  // next-state computation
  always_comb begin
    edge_up = pclk && !clk_d_reg;
    clk_d_next = pclk;
    store_next = store_reg; // hold by default
    if (le) begin
      store_next = din; // transparent
    end else if (!ce_n && edge_up) begin
      store_next = din; // clocked capture
    end
    drive_next = !oe_n;
    if (oe_n) begin
      mode_next = bt_pkg::BT_ISOLATE;
    end else if (le) begin
      mode_next = bt_pkg::BT_TRANSPARENT;
    end else if (ce_n) begin
      mode_next = bt_pkg::BT_INHIBIT; // edges ignored
    end else begin
      mode_next = bt_pkg::BT_STORED;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      store_reg <= bt_pkg::STORE_RST; // all zeros until loaded
      drive_reg <= 1'b0;
      clk_d_reg <= 1'b0;
      mode_reg <= bt_pkg::BT_ISOLATE;
    end else begin
      store_reg <= store_next;
      drive_reg <= drive_next;
      clk_d_reg <= clk_d_next;
      mode_reg <= mode_next;
    end
  end

  assign dout = store_reg;
  assign drive_en = drive_reg;
  assign mode = mode_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_transparent;
    le |=> dout == $past(din);
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent path lost data");

  property p_latched_hold;
    (!le && !ce_n && (pclk == clk_d_reg)) |=> $stable(dout);
  endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched output moved");

  property p_high_hold;
    ($fell(le) && pclk && clk_d_reg) ##1 (!le && pclk) |=> $stable(dout);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("clock high latch lost level");

  property p_clocked;
    (!le && !ce_n && pclk && !clk_d_reg) |=> dout == $past(din);
  endproperty
  a_clocked: assert property (p_clocked) else $error("rising edge missed capture");

  property p_isolate;
    oe_n |=> !drive_en ##0 mode == bt_pkg::BT_ISOLATE;
  endproperty
  a_isolate: assert property (p_isolate) else $error("output driven while disabled");

  property p_drive;
    !oe_n [*2] |-> drive_en;
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven");

  property p_inhibit;
    (!le && ce_n) |=> $stable(dout);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("clock inhibit failed");

  c_transparent: cover property (le ##1 le && $changed(dout));
  c_clocked: cover property (!le && !ce_n && edge_up ##1 $changed(dout));
  c_inhibit: cover property (!le && ce_n && edge_up);
endmodule

// ==== verilog/bt_pkg.sv ====
// constants and types of the latched bus transceiver
// How it works
// - eighteen separate bits, one store per direction
// - latch enable high passes input straight through
// - latch low, clock steady: output holds
// - clock high before latch fell: old level
// - rising clock edge captures input when enabled
// - output enable low drives, high isolates
// - clock enable high ignores clock edges
// - second direction mirrors first with own controls
package bt_pkg;
  localparam int DATA_W = 18; // bits per direction
  localparam int CTRL_W = 4; // oe_n, le, clk, ce_n per direction
  localparam int SYNC_W = 2 * CTRL_W + 2 * DATA_W; // synchronised pin vector
  // reset of synchronised pins: output enables and clock enables inactive
  localparam logic [SYNC_W-1:0] SYNC_RST = 44'h99000000000;
  localparam logic [DATA_W-1:0] STORE_RST = 18'h00000; // store after reset
  // apb register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] VIEW_OFS = 12'h008;
  localparam logic CTRL_RST = 1'b0; // view select after reset
  localparam int VIEW_SEL_BIT = 0; // control: 0 shows a-to-b store, 1 b-to-a
  localparam int STAT_AB_MODE = 0; // status field positions
  localparam int STAT_BA_MODE = 2;
  localparam int STAT_AB_DRV = 4;
  localparam int STAT_BA_DRV = 5;
  // operating mode of one direction
  typedef enum logic [1:0] {
    BT_ISOLATE = 2'h0,
    BT_TRANSPARENT = 2'h1,
    BT_STORED = 2'h2,
    BT_INHIBIT = 2'h3
  } bt_mode_t;
endpackage

// ==== verilog/bt_transceiver.sv ====
// top of the 18-bit latched bus transceiver with apb status port
`timescale 1ns/1ps
module bt_transceiver (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [bt_pkg::DATA_W-1:0] A_IN,
  output logic [bt_pkg::DATA_W-1:0] A_OUT,
  output logic A_OE,
  input wire logic [bt_pkg::DATA_W-1:0] B_IN,
  output logic [bt_pkg::DATA_W-1:0] B_OUT,
  output logic B_OE,
  input wire logic AB_OUTPUT_ENABLE_N,
  input wire logic AB_LATCH_ENABLE,
  input wire logic AB_CLOCK,
  input wire logic AB_CLOCK_ENABLE_N,
  input wire logic BA_OUTPUT_ENABLE_N,
  input wire logic BA_LATCH_ENABLE,
  input wire logic BA_CLOCK,
  input wire logic BA_CLOCK_ENABLE_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  logic [bt_pkg::SYNC_W-1:0] pins; // raw pins gathered
  logic [bt_pkg::SYNC_W-1:0] meta_reg, meta_next; // first sync stage
  logic [bt_pkg::SYNC_W-1:0] sync_reg, sync_next; // second sync stage
  logic ab_oe_n_s, ab_le_s, ab_clk_s, ab_ce_n_s; // synced a-to-b controls
  logic ba_oe_n_s, ba_le_s, ba_clk_s, ba_ce_n_s; // synced b-to-a controls
  logic [bt_pkg::DATA_W-1:0] a_in_s, b_in_s; // synced data
  bt_pkg::bt_mode_t ab_mode, ba_mode; // path modes
  logic ctrl_reg, ctrl_next; // view select
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic setup; // apb setup phase
  logic wr_done; // apb write completes this edge

  // true for mapped offsets
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == bt_pkg::CTRL_OFS) || (a == bt_pkg::STATUS_OFS) || (a == bt_pkg::VIEW_OFS);
  endfunction

  assign pins = {AB_OUTPUT_ENABLE_N, AB_LATCH_ENABLE, AB_CLOCK, AB_CLOCK_ENABLE_N,
                 BA_OUTPUT_ENABLE_N, BA_LATCH_ENABLE, BA_CLOCK, BA_CLOCK_ENABLE_N,
                 A_IN, B_IN};

  // two-stage synchroniser next values
  always_comb begin
    meta_next = pins;
    sync_next = meta_reg;
  end

  // synchroniser registers; enables come up inactive
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      meta_reg <= bt_pkg::SYNC_RST;
      sync_reg <= bt_pkg::SYNC_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  // slice the synchronised vector
  assign {ab_oe_n_s, ab_le_s, ab_clk_s, ab_ce_n_s,
          ba_oe_n_s, ba_le_s, ba_clk_s, ba_ce_n_s, a_in_s, b_in_s} = sync_reg;

  // a-to-b direction
  bt_path u_ab (
    .clk(SYS_CLK),
    .rst(RST),
    .din(a_in_s),
    .oe_n(ab_oe_n_s),
    .le(ab_le_s),
    .pclk(ab_clk_s),
    .ce_n(ab_ce_n_s),
    .dout(B_OUT),
    .drive_en(B_OE),
    .mode(ab_mode)
  );

  // b-to-a direction, same logic with its own controls
  bt_path u_ba (
    .clk(SYS_CLK),
    .rst(RST),
    .din(b_in_s),
    .oe_n(ba_oe_n_s),
    .le(ba_le_s),
    .pclk(ba_clk_s),
    .ce_n(ba_ce_n_s),
    .dout(A_OUT),
    .drive_en(A_OE),
    .mode(ba_mode)
  );

  // apb slave next values: zero wait states, answer in first access cycle
  always_comb begin
    setup = PSEL && !PENABLE;
    wr_done = PSEL && PENABLE && pready_reg && PWRITE;
    pready_next = setup;
    pslverr_next = setup && !addr_ok(PADDR); // unmapped offset
    prdata_next = prdata_reg;
    ctrl_next = ctrl_reg;
    if (setup) begin
      prdata_next = 32'h00000000;
      if (!PWRITE) begin
        unique case (PADDR)
          bt_pkg::CTRL_OFS: begin
            prdata_next[bt_pkg::VIEW_SEL_BIT] = ctrl_reg;
          end
          bt_pkg::STATUS_OFS: begin
            prdata_next[bt_pkg::STAT_AB_MODE +: 2] = ab_mode;
            prdata_next[bt_pkg::STAT_BA_MODE +: 2] = ba_mode;
            prdata_next[bt_pkg::STAT_AB_DRV] = B_OE;
            prdata_next[bt_pkg::STAT_BA_DRV] = A_OE;
          end
          bt_pkg::VIEW_OFS: begin
            prdata_next[bt_pkg::DATA_W-1:0] = ctrl_reg ? A_OUT : B_OUT;
          end
          default: begin
            prdata_next = 32'h00000000; // unmapped reads zero
          end
        endcase
      end
    end
    if (wr_done && (PADDR == bt_pkg::CTRL_OFS)) begin
      ctrl_next = PWDATA[bt_pkg::VIEW_SEL_BIT];
    end
  end

  // apb registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= bt_pkg::CTRL_RST;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;

  // checks share the system clock and, except the reset-state check, stay quiet while reset is applied
  // pin to output: two sync stages plus the store give three cycles
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_all_bits;
    ab_le_s |=> B_OUT == $past(a_in_s);
  endproperty
  a_all_bits: assert property (p_all_bits) else $error("a-to-b bits not carried");

  property p_mirror;
    ba_le_s |=> A_OUT == $past(b_in_s);
  endproperty
  a_mirror: assert property (p_mirror) else $error("b-to-a path not mirrored");

  property p_mirror_isolate;
    ba_oe_n_s |=> !A_OE;
  endproperty
  a_mirror_isolate: assert property (p_mirror_isolate) else $error("a port driven");

  property p_pin_latency;
    (AB_LATCH_ENABLE && !AB_OUTPUT_ENABLE_N) [*4] |-> B_OE && B_OUT == $past(A_IN, 3);
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("pin to pin latency wrong");

  // b-to-a pins reach the a port with the same latency
  property p_ba_latency;
    (BA_LATCH_ENABLE && !BA_OUTPUT_ENABLE_N) [*4] |-> A_OE && A_OUT == $past(B_IN, 3);
  endproperty
  a_ba_latency: assert property (p_ba_latency) else $error("b to a latency wrong");

  // a disabled b port stays released once the pin has settled
  property p_ab_off;
    AB_OUTPUT_ENABLE_N [*4] |-> !B_OE;
  endproperty
  a_ab_off: assert property (p_ab_off) else $error("b port driven while disabled");

  property p_reset_state;
    @(posedge SYS_CLK) disable iff (1'b0)
      RST |=> !A_OE && !B_OE && B_OUT == bt_pkg::STORE_RST && A_OUT == bt_pkg::STORE_RST;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_apb_ready;
    (PSEL && !PENABLE) |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

  // apb slave checks: error only comes with ready
  property p_slverr_ready;
    PSLVERR |-> PREADY;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready) else $error("error without ready");

  // an error answer carries zero read data
  property p_unmapped_zero;
    (PREADY && PSLVERR) |-> PRDATA == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("error read not zero");

  // a completed write to the control word lands at that edge
  property p_ctrl_write;
    (PSEL && PENABLE && PREADY && PWRITE && PADDR == bt_pkg::CTRL_OFS) |=>
      ctrl_reg == $past(PWDATA[bt_pkg::VIEW_SEL_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("view select write lost");

  c_apb_read: cover property (PSEL && PENABLE && PREADY && !PWRITE && PADDR == bt_pkg::VIEW_OFS);
  c_isolation: cover property (B_OE ##1 !B_OE);
endmodule
